// [hcd_chirp_ctrl.sv]
// Link-side controller for the high-speed chirp handshake
`include "hcd_params.svh"
`default_nettype none

module hcd_chirp_ctrl
  import hcd_pkg::*;
#(
  parameter int unsigned CHIRP_K_CYC = `HCD_CHIRP_MIN_US * `HCD_CLKOUT_FAST_MHZ,
  parameter int unsigned FB_CYC      = `HCD_FB_US * `HCD_CLKOUT_NOM_MHZ
) (
  input  wire logic       clk_i,         // System clock, 40 MHz
  input  wire logic       rst_i,         // Synchronous reset, high
  input  wire logic       start_i,       // Pulse: bus reset seen, begin
  input  wire logic       clkout_i,      // Transceiver link clock pin
  input  wire logic [1:0] linestate_i,   // Transceiver line state pins
  output logic [1:0]      opmode_o,      // Operating mode select
  output logic            xcvr_sel_o,    // Transceiver select, 1 = FS
  output logic            term_sel_o,    // Termination select, 1 = FS
  output logic            txvalid_o,     // Transmit valid
  output logic [7:0]      data_o,        // Transmit data
  output logic            busy_o,        // Handshake in progress
  output logic            hs_mode_o,     // Committed to high speed
  output logic            fs_mode_o,     // Fell back to full speed
  output logic            bus_active_o,  // Host chirps count as activity
  output logic [2:0]      chirp_cnt_o    // Accepted host chirps so far
);

  hcd_state_t state_q;
  hcd_state_t state_d;

  logic [1:0]            clk_sync_q;
  logic                  clk_prev_q;
  logic [1:0]            ls_meta_q;
  logic [1:0]            ls_q;
  logic                  tick;
  logic [`HCD_CNT_W-1:0] cnt_q;
  logic [`HCD_CNT_W-1:0] cnt_d;
  logic [2:0]            chirp_cnt_q;
  logic [2:0]            chirp_cnt_d;
  logic [1:0]            last_kj_q;
  logic [1:0]            last_kj_d;
  logic                  chirp_done;
  logic                  fb_due;
  logic                  kj_ok;
  logic                  seq_done;
  logic                  filt_en_q;

  hcd_filt_if fi ();

  // Two flip-flops on the pins; only the second stage is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sync_q <= 2'h0;
      ls_meta_q  <= `HCD_LS_SE0;
      ls_q       <= `HCD_LS_SE0;
    end else begin
      clk_sync_q <= {clk_sync_q[0], clkout_i};
      ls_meta_q  <= linestate_i;
      ls_q       <= ls_meta_q;
    end
  end

  // Edge finder on the synchronised link clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_sync_q[1];
    end
  end

  // One pulse per link clock rising edge; all timing counts these
  assign tick = clk_sync_q[1] && !clk_prev_q;

  // Filter hookup: line state samples, not the receive data path
  assign fi.en   = filt_en_q;
  assign fi.tick = tick;
  assign fi.ls   = ls_q;

  hcd_ls_filter u_filter (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .fi    (fi.filt)
  );

  // Timer limits, in link clock cycles
  assign chirp_done = tick && cnt_q == `HCD_CNT_W'(CHIRP_K_CYC - 1);
  assign fb_due     = tick && cnt_q == `HCD_CNT_W'(FB_CYC - 1);

  // A host chirp is good if it is K first, then alternates
  always_comb begin
    kj_ok = 1'b0;
    if (fi.acc && hcd_is_kj(fi.acc_ls)) begin
      if (chirp_cnt_q == 3'h0) begin
        kj_ok = fi.acc_ls == `HCD_LS_K;
      end else begin
        kj_ok = fi.acc_ls != last_kj_q;
      end
    end
  end

  assign seq_done = state_q == ST_LISTEN && kj_ok
                    && chirp_cnt_q == `HCD_SEQ_LEN - 3'h1;

  // Next phase; a new bus reset restarts from any phase
  always_comb begin
    state_d = state_q;
    if (start_i) begin
      state_d = ST_CHIRP;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_CHIRP: begin
          if (chirp_done) begin
            state_d = ST_LISTEN;
          end
        end
        ST_LISTEN: begin
          if (seq_done) begin
            state_d = ST_HS;
          end else if (fb_due) begin
            state_d = ST_FS;
          end
        end
        ST_HS: begin
          state_d = ST_HS;
        end
        ST_FS: begin
          state_d = ST_FS;
        end
      endcase
    end
  end

  // Phase register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Link clock counter: restarts at each phase change
  always_comb begin
    cnt_d = cnt_q;
    if (state_d != state_q || start_i) begin
      cnt_d = '0;
    end else if (tick && (state_q == ST_CHIRP || state_q == ST_LISTEN)) begin
      cnt_d = cnt_q + `HCD_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Host chirp counter; only counts after own chirp has ended, since
  // our own K would otherwise pose as the first host K
  always_comb begin
    chirp_cnt_d = chirp_cnt_q;
    last_kj_d   = last_kj_q;
    if (start_i) begin
      chirp_cnt_d = 3'h0;
      last_kj_d   = `HCD_LS_SE0;
    end else if (state_q == ST_LISTEN && kj_ok) begin
      chirp_cnt_d = chirp_cnt_q + 3'h1;
      last_kj_d   = fi.acc_ls;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chirp_cnt_q <= 3'h0;
      last_kj_q   <= `HCD_LS_SE0;
    end else begin
      chirp_cnt_q <= chirp_cnt_d;
      last_kj_q   <= last_kj_d;
    end
  end

  // Filter runs from the first cycle of own chirp to the end of listening
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_en_q <= 1'b0;
    end else begin
      filt_en_q <= state_d == ST_CHIRP || state_d == ST_LISTEN;
    end
  end

  // Transceiver controls follow the next phase, so pins and phase agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opmode_o   <= `HCD_OPM_NORMAL;
      xcvr_sel_o <= `HCD_SEL_FS;
      term_sel_o <= `HCD_SEL_FS;
      txvalid_o  <= 1'b0;
      data_o     <= `HCD_TX_IDLE;
    end else begin
      unique case (state_d)
        ST_CHIRP: begin
          opmode_o   <= `HCD_OPM_NOSTUFF;
          xcvr_sel_o <= `HCD_SEL_HS;
          term_sel_o <= `HCD_SEL_FS;
          txvalid_o  <= 1'b1;
          data_o     <= `HCD_TX_CHIRP;
        end
        ST_LISTEN: begin
          opmode_o   <= `HCD_OPM_NOSTUFF;
          xcvr_sel_o <= `HCD_SEL_HS;
          term_sel_o <= `HCD_SEL_FS;
          txvalid_o  <= 1'b0;
          data_o     <= `HCD_TX_IDLE;
        end
        ST_HS: begin
          opmode_o   <= `HCD_OPM_NORMAL;
          xcvr_sel_o <= `HCD_SEL_HS;
          term_sel_o <= `HCD_SEL_HS;
          txvalid_o  <= 1'b0;
          data_o     <= `HCD_TX_IDLE;
        end
        ST_FS: begin
          opmode_o   <= `HCD_OPM_NORMAL;
          xcvr_sel_o <= `HCD_SEL_FS;
          term_sel_o <= `HCD_SEL_FS;
          txvalid_o  <= 1'b0;
          data_o     <= `HCD_TX_IDLE;
        end
        ST_IDLE: begin
          opmode_o   <= `HCD_OPM_NORMAL;
          xcvr_sel_o <= `HCD_SEL_FS;
          term_sel_o <= `HCD_SEL_FS;
          txvalid_o  <= 1'b0;
          data_o     <= `HCD_TX_IDLE;
        end
      endcase
    end
  end

  // Status for the surrounding link logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o      <= 1'b0;
      hs_mode_o   <= 1'b0;
      fs_mode_o   <= 1'b0;
      chirp_cnt_o <= 3'h0;
    end else begin
      busy_o      <= state_d == ST_CHIRP || state_d == ST_LISTEN;
      hs_mode_o   <= state_d == ST_HS;
      fs_mode_o   <= state_d == ST_FS;
      chirp_cnt_o <= chirp_cnt_d;
    end
  end

  // Activity flag keeps suspend and reset timers quiet while the host
  // chirps; the SE0 tail after them is left to those timers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_active_o <= 1'b0;
    end else begin
      bus_active_o <= (state_d == ST_LISTEN && chirp_cnt_d != 3'h0)
                      || (state_d == ST_HS && hcd_is_kj(ls_q));
    end
  end

  // Helper: own chirp length in link clock edges; a restart starts it over
  logic [`HCD_CNT_W-1:0] chirp_len_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || start_i || !txvalid_o) begin
      chirp_len_q <= '0;
    end else if (tick) begin
      chirp_len_q <= chirp_len_q + `HCD_CNT_W'(1);
    end
  end

  a_chirp_setup: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_CHIRP |-> opmode_o == `HCD_OPM_NOSTUFF && txvalid_o
      && xcvr_sel_o == `HCD_SEL_HS && term_sel_o == `HCD_SEL_FS && data_o == `HCD_TX_CHIRP)
    else $error("chirp pins wrong");

  a_chirp_start: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i |=> txvalid_o && state_q == ST_CHIRP)
    else $error("chirp did not start one cycle after start");

  a_chirp_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(txvalid_o) && !$past(start_i) |-> $past(chirp_len_q) == `HCD_CNT_W'(CHIRP_K_CYC - 1))
    else $error("own chirp not full length");

  a_listen_after: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_CHIRP && chirp_done && !start_i |=> state_q == ST_LISTEN && filt_en_q)
    else $error("listening did not follow chirp");

  a_fs_fallback: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_LISTEN && fb_due && !seq_done && !start_i
      |=> xcvr_sel_o == `HCD_SEL_FS && fs_mode_o)
    else $error("no fallback to FS at timer end");

  a_hs_commit: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_done && !start_i |=> term_sel_o == `HCD_SEL_HS && hs_mode_o)
    else $error("HS terminations not applied on detection");

  a_hs_needs_six: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(hs_mode_o) |-> chirp_cnt_o == `HCD_SEQ_LEN)
    else $error("HS commit without six chirps");

  a_count_alt: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_LISTEN && fi.acc && fi.acc_ls == last_kj_q && !start_i
      |=> chirp_cnt_q == $past(chirp_cnt_q))
    else $error("repeated chirp state was counted");

  a_hs_tail: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_HS && ls_q == `HCD_LS_SE0 && !start_i |=> state_q == ST_HS)
    else $error("SE0 tail left HS state");

  a_bus_active: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_LISTEN && chirp_cnt_q != 3'h0 |-> bus_active_o)
    else $error("host chirps not flagged as activity");

endmodule

`default_nettype wire

// [hcd_filt_if.sv]
// Carrier between the handshake controller and its line state filter
`default_nettype none

interface hcd_filt_if;
  logic       en;      // Filter running
  logic       tick;    // One link clock rising edge
  logic [1:0] ls;      // Synchronised line state
  logic       acc;     // Pulse: state held long enough
  logic [1:0] acc_ls;  // The state that was accepted

  modport link (output en, output tick, output ls, input acc, input acc_ls);
  modport filt (input en, input tick, input ls, output acc, output acc_ls);
endinterface

`default_nettype wire

// [hcd_ls_filter.sv]
// Line state filter: accepts a state held over many link clock edges
`include "hcd_params.svh"
`default_nettype none

module hcd_ls_filter
  import hcd_pkg::*;
(
  input  wire logic clk_i,  // System clock
  input  wire logic rst_i,  // Synchronous reset, high
  hcd_filt_if.filt  fi      // Samples in, accepted states out
);

  logic [1:0]            last_q;
  logic [`HCD_RUN_W-1:0] run_q;

  // Run length of the current state, counted in link clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i || !fi.en) begin
      last_q <= `HCD_LS_SE0;
      run_q  <= '0;
    end else if (fi.tick) begin
      if (run_q == '0 || fi.ls != last_q) begin
        last_q <= fi.ls;  // Any glitch restarts the run
        run_q  <= `HCD_RUN_W'(1);
      end else if (run_q != `HCD_RUN_W'(`HCD_FILT_CYC)) begin
        run_q <= run_q + `HCD_RUN_W'(1);  // Saturate: one pulse per hold
      end
    end
  end

  // One pulse when the run reaches the hold length
  always_ff @(posedge clk_i) begin
    if (rst_i || !fi.en) begin
      fi.acc    <= 1'b0;
      fi.acc_ls <= `HCD_LS_SE0;
    end else begin
      fi.acc <= fi.tick && run_q != '0 && fi.ls == last_q
                && run_q == `HCD_RUN_W'(`HCD_FILT_CYC - 1);
      fi.acc_ls <= last_q;
    end
  end

  a_filter_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    fi.acc |-> run_q == `HCD_RUN_W'(`HCD_FILT_CYC) && fi.acc_ls == last_q)
    else $error("accepted state without full hold");

  a_filter_single: assert property (@(posedge clk_i) disable iff (rst_i)
    fi.acc |=> !fi.acc)
    else $error("accept pulse longer than one cycle");

endmodule

`default_nettype wire

// [hcd_params.svh]
// Constants for the high-speed chirp handshake controller
`ifndef HCD_PARAMS_SVH
`define HCD_PARAMS_SVH

// Line state codes as reported by the transceiver
`define HCD_LS_SE0 2'h0
`define HCD_LS_J   2'h1
`define HCD_LS_K   2'h2
`define HCD_LS_SE1 2'h3

// Operating mode codes
`define HCD_OPM_NORMAL  2'h0
`define HCD_OPM_NOSTUFF 2'h2

// Transceiver and termination select levels
`define HCD_SEL_HS 1'h0
`define HCD_SEL_FS 1'h1

// Transmit data that makes a chirp K, and the idle transmit data
`define HCD_TX_CHIRP 8'h00
`define HCD_TX_IDLE  8'h00

// Link clock rates in MHz: fast edge of tolerance and nominal
`define HCD_CLKOUT_FAST_MHZ 66
`define HCD_CLKOUT_NOM_MHZ  60

// Least width of own chirp K, in microseconds
`define HCD_CHIRP_MIN_US 1000

// Wait after own chirp before falling back to FS, in microseconds
`define HCD_FB_US 1500

// Continuous line state hold before acceptance, in nanoseconds
`define HCD_FILT_NS 2500

// Link clock cycles of continuous hold (rounded at the fast clock)
`define HCD_FILT_CYC ((`HCD_FILT_NS * `HCD_CLKOUT_FAST_MHZ) / 1000)

// Number of alternating host chirps that prove HS capability
`define HCD_SEQ_LEN 3'h6

// Width of the link clock cycle counter
`define HCD_CNT_W 18

// Width of the filter run counter
`define HCD_RUN_W 8

`endif

// [hcd_pkg.sv]
// Types and shared decoding for the chirp handshake controller
`include "hcd_params.svh"
`default_nettype none

package hcd_pkg;

  // Handshake phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHIRP,
    ST_LISTEN,
    ST_HS,
    ST_FS
  } hcd_state_t;

  // True for a chirp K or chirp J line state
  function automatic logic hcd_is_kj(input logic [1:0] ls);
    hcd_is_kj = (ls == `HCD_LS_K) || (ls == `HCD_LS_J);
  endfunction

endpackage

`default_nettype wire

// [hcd_xcvr_model.sv]
// Behavioural transceiver model: link clock and line state with host chirps
`include "hcd_params.svh"
`default_nettype none

module hcd_xcvr_model (
  input  wire logic       txvalid_i,    // Own chirp from the controller
  input  wire logic       xcvr_sel_i,   // Transceiver select, 1 = FS
  input  wire logic       host_en_i,    // Host port is HS capable
  input  wire logic [8:0] chirp_len_i,  // Host chirp length in link clocks
  output logic            clkout_o,     // Free running link clock
  output logic [1:0]      linestate_o   // Unfiltered line state
);
  timeunit 1ns;
  timeprecision 1ps;

  // Link clock runs free while the transceiver is powered, 200 ns period
  initial clkout_o = 1'b0;
  always #100 clkout_o = ~clkout_o;

  // Host holds SE0 for reset; FS config means the pull-up is overpowered
  always begin
    linestate_o = `HCD_LS_SE0;
    @(posedge txvalid_i);
    #1;  // Let the transceiver select settle, it moves on the same edge
    linestate_o = (xcvr_sel_i == `HCD_SEL_HS) ? `HCD_LS_K : `HCD_LS_J;
    @(negedge txvalid_i);
    linestate_o = `HCD_LS_SE0;
    // Host answers well inside 100 us, toggling every chirp_len clocks
    repeat (20) @(posedge clkout_o);
    if (host_en_i) begin
      for (int i = 0; i < 8; i++) begin
        linestate_o = i[0] ? `HCD_LS_J : `HCD_LS_K;
        repeat (chirp_len_i) @(posedge clkout_o);
      end
      linestate_o = `HCD_LS_SE0;
    end
  end
endmodule

`default_nettype wire

// [tb.sv]
// Self-checking bench for the chirp handshake controller
`include "hcd_params.svh"
`default_nettype none

module tb;
  import hcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned CK = 40;
  localparam int unsigned FB = 2200;

  typedef struct packed {logic hs; logic [2:0] cnt;} hcd_exp_t;

  logic       clk_i, rst_i, start_i, host_en, clkout_w, txvalid_o, xcvr_sel_o;
  logic       term_sel_o, busy_o, hs_mode_o, fs_mode_o, bus_active_o, done_q;
  logic [1:0] linestate_w, opmode_o;
  logic [7:0] data_o;
  logic [2:0] chirp_cnt_o;
  logic [8:0] chirp_len;
  hcd_exp_t   exp_q[$];
  hcd_exp_t   e;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cyc = 0;

  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  hcd_chirp_ctrl #(.CHIRP_K_CYC(CK), .FB_CYC(FB)) u_hcd_chirp_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .clkout_i(clkout_w),
    .linestate_i(linestate_w), .opmode_o(opmode_o), .xcvr_sel_o(xcvr_sel_o),
    .term_sel_o(term_sel_o), .txvalid_o(txvalid_o), .data_o(data_o),
    .busy_o(busy_o), .hs_mode_o(hs_mode_o), .fs_mode_o(fs_mode_o),
    .bus_active_o(bus_active_o), .chirp_cnt_o(chirp_cnt_o));

  hcd_xcvr_model u_hcd_xcvr_model (
    .txvalid_i(txvalid_o), .xcvr_sel_i(xcvr_sel_o), .host_en_i(host_en),
    .chirp_len_i(chirp_len), .clkout_o(clkout_w), .linestate_o(linestate_w));

  task automatic chk(input string what, input logic [7:0] ex, input logic [7:0] got);
    total_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog: the four handshakes need about 76000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 95000) begin
      bad_count++;
      $display("ERROR watchdog expected done seen hang");
      report_and_stop();
    end
  end

  // Result watcher: each new HS or FS commit takes the oldest note;
  // runs on the falling edge so the outputs have settled
  always @(negedge clk_i) begin
    done_q <= hs_mode_o | fs_mode_o;
    if (rst_i === 1'b0 && (hs_mode_o | fs_mode_o) === 1'b1 && done_q === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("unexpected_result", 8'h00, 8'h01);
      end else begin
        e = exp_q.pop_front();
        chk("hs_mode", {7'h0, e.hs}, {7'h0, hs_mode_o});
        chk("fs_mode", {7'h0, ~e.hs}, {7'h0, fs_mode_o});
        chk("term_sel", {7'h0, ~e.hs}, {7'h0, term_sel_o});
        chk("xcvr_sel", {7'h0, ~e.hs}, {7'h0, xcvr_sel_o});
        chk("chirp_cnt", {5'h0, e.cnt}, {5'h0, chirp_cnt_o});
        chk("opmode", 8'h00, {6'h0, opmode_o});
      end
    end
  end

  // Start pulse on the falling edge, answer looked at one cycle on
  task automatic kick();
    @(negedge clk_i) start_i = 1'b1;
    @(negedge clk_i) start_i = 1'b0;
    chk("txvalid", 8'h01, {7'h0, txvalid_o});
    chk("opmode", 8'h02, {6'h0, opmode_o});
    chk("xcvr_sel", 8'h00, {7'h0, xcvr_sel_o});
    chk("data", 8'h00, data_o);
    chk("status", 8'h04, {5'h0, busy_o, hs_mode_o, fs_mode_o});
    chk("chirp_cnt", 8'h00, {5'h0, chirp_cnt_o});
  endtask

  // One handshake; restart aborts the first listen phase after 100 link clocks
  task automatic run(input logic host, input logic [8:0] len, input logic exp_hs,
                     input logic [2:0] exp_cnt, input logic restart);
    int n;
    @(negedge clk_i);
    host_en = host;
    chirp_len = len;
    exp_q.push_back(hcd_exp_t'{exp_hs, exp_cnt});
    for (int p = 0; p <= restart; p++) begin
      kick();
      n = 0;
      forever begin
        @(posedge clkout_w);
        if (txvalid_o !== 1'b1) break;
        n++;
      end
      chk("chirp_len_ok", 8'h01, {7'h0, (n >= CK - 1 && n <= CK + 1)});
      if (p < restart) repeat (100) @(posedge clkout_w);
    end
    n = 0;
    while ((hs_mode_o | fs_mode_o) !== 1'b1) begin
      @(posedge clkout_w);
      n++;
      if (host && chirp_cnt_o === 3'h3 && busy_o === 1'b1 && n < 5000) begin
        chk("bus_active", 8'h01, {7'h0, bus_active_o});
        n = 5000;
      end
    end
    if (!exp_hs) begin
      chk("fallback_ok", 8'h01, {7'h0, (n >= FB - 2 && n <= FB + 2)});
    end else begin
      while (linestate_w !== `HCD_LS_SE0) @(posedge clk_i);
      repeat (400) @(negedge clk_i);
      chk("hs_after_se0", 8'h01, {7'h0, hs_mode_o});
      chk("bus_idle", 8'h00, {7'h0, bus_active_o});
    end
    repeat (20) @(negedge clk_i);
    $display("test done host=%0d len=%0d restart=%0d", host, len, restart);
  endtask

  initial begin
    rst_i = 1'b1;
    start_i = 1'b0;
    host_en = 1'b0;
    chirp_len = 9'h0c8;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    void'($urandom(81635));
    chk("reset_cfg", 8'h03, {6'h0, xcvr_sel_o, term_sel_o});
    chk("reset_tx", 8'h00, {5'h0, txvalid_o, opmode_o});
    $display("test done reset");
    // HS capable host, toggles between 40 and 60 us
    run(1'b1, 9'(200 + $urandom % 100), 1'b1, 3'h6, 1'b0);
    // FS only host: no chirps at all
    run(1'b0, 9'h0c8, 1'b0, 3'h0, 1'b0);
    // Chirps shorter than the 165 clock hold are never counted
    run(1'b1, 9'h096, 1'b0, 3'h0, 1'b0);
    // New bus reset during listen restarts the whole machine
    run(1'b0, 9'h0c8, 1'b0, 3'h0, 1'b1);
    report_and_stop();
  end
endmodule

`default_nettype wire
